// ===== hw/ssale_slave.sv
// Slave message handling: frame capture and checks, error counting, access log and exception replies.
// Assumes own_addr, busy and the format come from logic on the same clock, and that the register
// side answers each query pulse with exactly one result pulse and sends normal read/write replies itself.

`default_nettype none

module ssale_slave #(
	parameter int unsigned BIT_CYCLES = ssale_pkg::BIT_CYCLES,
	parameter int unsigned GAP_CYCLES = ssale_pkg::GAP_CYCLES,
	parameter int unsigned ERR_W      = 16
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     arst_n,
	// Serial line and its settings
	input  wire logic                     rxd,
	output logic                          txd,
	input  wire ssale_pkg::ssale_fmt_s    serial_format_setting,
	input  wire logic [7:0]               own_addr,
	input  wire logic                     busy,
	// Register access hand-off
	output logic                          query_valid,
	output ssale_pkg::ssale_query_s       query,
	input  wire logic                     result_valid,
	input  wire ssale_pkg::ssale_result_s result,
	// Error reporting
	output logic [ERR_W-1:0]              comm_error_counter,
	output logic                          minor_fault_output
);
	localparam int unsigned GW = $clog2(GAP_CYCLES + 1);

	typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_APP, ST_SEND} ssale_state_e;

	ssale_state_e    state_q;
	logic            rx_valid;
	logic [7:0]      rx_data;
	logic            rx_par_err;
	logic            rx_frm_err;
	logic            rx_active;
	logic [7:0]      cnt_q;
	logic [5:0][7:0] hdr_q;
	logic [15:0]     crc_q;
	logic            char_err_q;
	logic [GW-1:0]   gap_q;
	logic [15:0]     log_start_q;
	logic [15:0]     log_count_q;
	logic [15:0]     snap_start_q;
	logic [15:0]     snap_count_q;
	logic            resp_exc_q;
	logic [7:0]      resp_code_q;
	logic [2:0]      tx_idx_q;
	logic [15:0]     crc_tx_q;
	logic            tx_valid;
	logic            tx_ready;
	logic [7:0]      tx_byte;
	logic            tx_fire;
	logic [2:0]      resp_len;
	logic            overrun;
	logic            frame_end;
	logic            in_check;
	logic            len_bad;
	logic            crc_bad;
	logic            frame_good;
	logic            bcast;
	logic            accept;
	logic            is_rw;
	logic            dec_log;
	logic            dec_rw;
	logic            dec_bad;
	logic            app_done;
	logic [15:0]     q_count;
	logic [7:0]      rw_code;
	logic            rw_ok;
	logic [2:0]      err_inc;

	// ----------------------------------------------------------------
	// Line
	// ----------------------------------------------------------------
	ssale_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
		.clock      (clock),
		.arst_n     (arst_n),
		.rxd        (rxd),
		.fmt        (serial_format_setting),
		.byte_valid (rx_valid),
		.byte_data  (rx_data),
		.parity_err (rx_par_err),
		.framing_err(rx_frm_err),
		.active     (rx_active)
	);

	ssale_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
		.clock     (clock),
		.arst_n    (arst_n),
		.fmt       (serial_format_setting),
		.byte_valid(tx_valid),
		.byte_data (tx_byte),
		.byte_ready(tx_ready),
		.txd       (txd)
	);

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	assign overrun    = rx_valid && state_q != ST_RX;
	assign frame_end  = state_q == ST_RX && cnt_q != 8'h00 && !rx_active && gap_q == GW'(GAP_CYCLES);
	assign in_check   = state_q == ST_CHECK;
	assign len_bad    = cnt_q < ssale_pkg::MIN_FRAME_BYTES;
	assign crc_bad    = crc_q != ssale_pkg::CRC_GOOD;
	assign frame_good = in_check && !len_bad && !crc_bad && !char_err_q;
	assign bcast      = hdr_q[0] == ssale_pkg::ADDR_BROADCAST;
	assign accept     = frame_good && (hdr_q[0] == own_addr || bcast) && !busy;
	assign is_rw      = hdr_q[1] == ssale_pkg::FN_READ || hdr_q[1] == ssale_pkg::FN_WRITE_MULTI;
	assign dec_log    = accept && hdr_q[1] == ssale_pkg::FN_ACCESS_LOG && !bcast;
	assign dec_rw     = accept && is_rw;
	assign dec_bad    = accept && !is_rw && hdr_q[1] != ssale_pkg::FN_ACCESS_LOG;
	assign app_done   = state_q == ST_APP && result_valid;
	assign q_count    = {hdr_q[4], hdr_q[5]};
	assign rw_ok      = app_done && rw_code == ssale_pkg::EXC_NONE;

	// Missing or locked registers inside the span are the register side's to zero or drop.
	always_comb begin
		if (q_count == 16'h0000 || result.data_bad) begin
			rw_code = ssale_pkg::EXC_ILLEGAL_DATA;
		end else if (result.ok_count == 16'h0000) begin
			rw_code = ssale_pkg::EXC_ILLEGAL_ADDR;
		end else begin
			rw_code = ssale_pkg::EXC_NONE;
		end
	end

	assign query_valid = in_check && dec_rw;
	assign query       = '{func: hdr_q[1], start: {hdr_q[2], hdr_q[3]}, count: q_count};

	// ----------------------------------------------------------------
	// Frame capture
	// ----------------------------------------------------------------
	// Only the first six bytes are kept; longer write frames still run through the CRC.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q      <= 8'h00;
			hdr_q      <= '0;
			crc_q      <= ssale_pkg::CRC_INIT;
			char_err_q <= 1'b0;
		end else if (in_check) begin
			cnt_q      <= 8'h00;
			crc_q      <= ssale_pkg::CRC_INIT;
			char_err_q <= 1'b0;
		end else if (rx_valid && state_q == ST_RX) begin
			if (cnt_q < 8'h06) begin
				hdr_q[cnt_q[2:0]] <= rx_data;
			end
			if (cnt_q != 8'hff) begin
				cnt_q <= cnt_q + 8'h01;
			end
			crc_q <= ssale_pkg::crc16_byte(crc_q, rx_data);
			if (rx_par_err || rx_frm_err) begin
				char_err_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap_q <= '0;
		end else if (rx_active || rx_valid || cnt_q == 8'h00) begin
			gap_q <= '0;
		end else if (gap_q != GW'(GAP_CYCLES)) begin
			gap_q <= gap_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_RX;
		end else begin
			case (state_q)
				ST_RX: begin
					if (frame_end) begin
						state_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (dec_log || (dec_bad && !bcast)) begin
						state_q <= ST_SEND;
					end else if (dec_rw) begin
						state_q <= ST_APP;
					end else begin
						state_q <= ST_RX;
					end
				end
				ST_APP: begin
					if (result_valid) begin
						state_q <= (rw_code != ssale_pkg::EXC_NONE && !bcast) ? ST_SEND : ST_RX;
					end
				end
				ST_SEND: begin
					if (tx_fire && tx_idx_q == resp_len + 3'h1) begin
						state_q <= ST_RX;
					end
				end
				default: begin
					state_q <= ST_RX;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Access log
	// ----------------------------------------------------------------
	// The start is kept as carried on the wire, the register number less 40001.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			log_start_q <= ssale_pkg::LOG_RESET;
			log_count_q <= ssale_pkg::LOG_RESET;
		end else if (rw_ok) begin
			log_start_q <= result.ok_start;
			log_count_q <= result.ok_count;
		end else if (app_done || dec_log || dec_bad) begin
			log_start_q <= ssale_pkg::LOG_RESET;
			log_count_q <= ssale_pkg::LOG_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Reply
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			snap_start_q <= ssale_pkg::LOG_RESET;
			snap_count_q <= ssale_pkg::LOG_RESET;
			resp_exc_q   <= 1'b0;
			resp_code_q  <= ssale_pkg::EXC_NONE;
		end else if (dec_log) begin
			snap_start_q <= log_start_q;
			snap_count_q <= log_count_q;
			resp_exc_q   <= 1'b0;
		end else if (dec_bad) begin
			resp_exc_q  <= 1'b1;
			resp_code_q <= ssale_pkg::EXC_ILLEGAL_FUNC;
		end else if (app_done) begin
			resp_exc_q  <= 1'b1;
			resp_code_q <= rw_code;
		end
	end

	assign resp_len = resp_exc_q ? 3'h3 : 3'h6;
	assign tx_valid = state_q == ST_SEND;
	assign tx_fire  = tx_valid && tx_ready;

	always_comb begin
		tx_byte = 8'h00;
		case (tx_idx_q)
			3'h0: tx_byte = hdr_q[0];
			3'h1: tx_byte = resp_exc_q ? (hdr_q[1] | ssale_pkg::FN_EXC_FLAG) : ssale_pkg::FN_ACCESS_LOG;
			3'h2: tx_byte = resp_exc_q ? resp_code_q : snap_start_q[15:8];
			3'h3: tx_byte = snap_start_q[7:0];
			3'h4: tx_byte = snap_count_q[15:8];
			3'h5: tx_byte = snap_count_q[7:0];
			default: tx_byte = 8'h00;
		endcase
		if (tx_idx_q == resp_len) begin
			tx_byte = crc_tx_q[7:0];
		end else if (tx_idx_q == resp_len + 3'h1) begin
			tx_byte = crc_tx_q[15:8];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_idx_q <= 3'h0;
			crc_tx_q <= ssale_pkg::CRC_INIT;
		end else if (state_q != ST_SEND) begin
			tx_idx_q <= 3'h0;
			crc_tx_q <= ssale_pkg::CRC_INIT;
		end else if (tx_fire) begin
			tx_idx_q <= tx_idx_q + 3'h1;
			if (tx_idx_q < resp_len) begin
				crc_tx_q <= ssale_pkg::crc16_byte(crc_tx_q, tx_byte);
			end
		end
	end

	// ----------------------------------------------------------------
	// Error reporting
	// ----------------------------------------------------------------
	// Errors only count and flag; nothing here halts the drive or the receiver.
	assign err_inc = {2'h0, rx_par_err} + {2'h0, rx_frm_err} + {2'h0, overrun}
		+ {2'h0, in_check && len_bad} + {2'h0, in_check && !len_bad && crc_bad};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			comm_error_counter <= '0;
		end else begin
			comm_error_counter <= comm_error_counter + ERR_W'(err_inc);
		end
	end

	// A new error wins over the clear that a clean frame would bring.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			minor_fault_output <= 1'b0;
		end else if (err_inc != 3'h0) begin
			minor_fault_output <= 1'b1;
		end else if (frame_good) begin
			minor_fault_output <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_crc_hi;
		tx_fire && tx_idx_q == resp_len + 3'h1;
	endsequence

	sequence s_back_rx;
		state_q == ST_RX;
	endsequence

	log_store_a: assert property (
		rw_ok |=> log_start_q == $past(result.ok_start) && log_count_q == $past(result.ok_count))
		else $error("access log not stored");
	log_clear_a: assert property (
		(dec_log || dec_bad) |=> log_start_q == 16'h0000 && log_count_q == 16'h0000)
		else $error("access log not cleared");
	exc_func_a: assert property (
		dec_bad && !bcast |=> state_q == ST_SEND && resp_exc_q && resp_code_q == 8'h01)
		else $error("illegal function not answered");
	exc_echo_a: assert property (
		tx_fire && resp_exc_q && tx_idx_q == 3'h1 |-> tx_byte == (hdr_q[1] | 8'h80))
		else $error("exception function byte wrong");
	err_quiet_a: assert property (
		in_check && !frame_good |=> state_q == ST_RX)
		else $error("reply after faulty frame");
	bcast_quiet_a: assert property (
		app_done && bcast |=> state_q == ST_RX)
		else $error("reply to broadcast");
	no_addr_a: assert property (
		app_done && !bcast && q_count != 16'h0000 && !result.data_bad && result.ok_count == 16'h0000
		|=> state_q == ST_SEND && resp_code_q == 8'h02)
		else $error("missing registers not refused");
	short_frame_a: assert property (
		in_check && len_bad |=> comm_error_counter != $past(comm_error_counter) && state_q == ST_RX)
		else $error("short frame not counted");
	fault_out_a: assert property (
		rx_frm_err || rx_par_err |=> minor_fault_output)
		else $error("minor fault not raised");
	crc_last_a: assert property (
		s_crc_hi |=> s_back_rx)
		else $error("reply not ended after CRC");

endmodule

`default_nettype wire

// ===== hw/ssale_pkg.sv
// Constants, types and shared functions of the serial slave access-log and error block.
// Assumes a single 20 MHz clock and an RTU line format chosen by the drive's settings.

`default_nettype none

package ssale_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned BAUD_DEFAULT    = 19200;
	localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_DEFAULT;
	localparam int unsigned CHAR_BITS       = 11;
	localparam int unsigned GAP_TENTH_CHARS = 35;
	localparam int unsigned GAP_CYCLES      = BIT_CYCLES * CHAR_BITS * GAP_TENTH_CHARS / 10;

	// ----------------------------------------------------------------
	// Message encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  FN_READ          = 8'h03;
	localparam logic [7:0]  FN_WRITE_MULTI   = 8'h10;
	localparam logic [7:0]  FN_ACCESS_LOG    = 8'h46;
	localparam logic [7:0]  FN_EXC_FLAG      = 8'h80;
	localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0]  EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0]  EXC_ILLEGAL_DATA = 8'h03;
	localparam logic [7:0]  EXC_NONE         = 8'h00;
	localparam logic [7:0]  ADDR_BROADCAST   = 8'h00;
	localparam logic [7:0]  MIN_FRAME_BYTES  = 8'h04;
	localparam int unsigned REG_NUMBER_BASE  = 40001;
	localparam logic [15:0] LOG_RESET        = 16'h0000;
	localparam logic [15:0] CRC_INIT         = 16'hffff;
	localparam logic [15:0] CRC_POLY         = 16'ha001;
	localparam logic [15:0] CRC_GOOD         = 16'h0000;
	localparam logic [1:0]  PAR_NONE         = 2'h0;
	localparam logic [1:0]  PAR_ODD          = 2'h1;
	localparam logic [1:0]  PAR_EVEN         = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] parity;
		logic       two_stop;
	} ssale_fmt_s;

	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] start;
		logic [15:0] count;
	} ssale_query_s;

	typedef struct packed {
		logic [15:0] ok_start;
		logic [15:0] ok_count;
		logic        data_bad;
	} ssale_result_s;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] mode);
		return (mode == PAR_ODD) ? ~^data : ^data;
	endfunction

endpackage

`default_nettype wire

// ===== hw/ssale_rx.sv
// Character receiver: samples the line at mid-bit and checks parity and stop bits.
// Assumes the line idles high and the format does not change while a character is in flight.

`default_nettype none

module ssale_rx #(
	parameter int unsigned BIT_CYCLES = ssale_pkg::BIT_CYCLES
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// Line and format
	input  wire logic                  rxd,
	input  wire ssale_pkg::ssale_fmt_s fmt,
	// Received characters
	output logic                       byte_valid,
	output logic [7:0]                 byte_data,
	output logic                       parity_err,
	output logic                       framing_err,
	output logic                       active
);
	localparam int unsigned TW = $clog2(BIT_CYCLES + 1);

	typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_DONE} ssale_rx_state_e;

	ssale_rx_state_e state_q;
	logic [2:0]      sync_q;
	logic            line_q;
	logic [TW-1:0]   tick_q;
	logic [3:0]      nbit_q;
	logic [11:0]     samp_q;
	logic            has_par;
	logic [3:0]      last_bit;

	assign has_par  = fmt.parity != ssale_pkg::PAR_NONE;
	assign last_bit = 4'h9 + {3'h0, has_par} + {3'h0, fmt.two_stop};
	assign active   = state_q != RX_IDLE;

	// ----------------------------------------------------------------
	// Synchroniser
	// ----------------------------------------------------------------
	// A level only counts once the second and third stages agree, which filters single-cycle glitches.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync_q <= 3'h7;
			line_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], rxd};
			if (sync_q[1] == sync_q[2]) begin
				line_q <= sync_q[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bit sampling
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= RX_IDLE;
			tick_q  <= '0;
			nbit_q  <= 4'h0;
			samp_q  <= 12'h000;
		end else begin
			case (state_q)
				RX_IDLE: begin
					if (!line_q) begin
						state_q <= RX_BITS;
						tick_q  <= TW'(BIT_CYCLES / 2);
						nbit_q  <= 4'h0;
					end
				end
				RX_BITS: begin
					if (tick_q != '0) begin
						tick_q <= tick_q - 1'b1;
					end else begin
						samp_q[nbit_q] <= line_q;
						tick_q         <= TW'(BIT_CYCLES - 1);
						nbit_q         <= nbit_q + 4'h1;
						if (nbit_q == 4'h0 && line_q) begin
							state_q <= RX_IDLE;
						end else if (nbit_q == last_bit) begin
							state_q <= RX_DONE;
						end
					end
				end
				RX_DONE: begin
					state_q <= RX_IDLE;
				end
				default: begin
					state_q <= RX_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Character checks
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			byte_valid  <= 1'b0;
			byte_data   <= 8'h00;
			parity_err  <= 1'b0;
			framing_err <= 1'b0;
		end else begin
			byte_valid <= state_q == RX_DONE;
			if (state_q == RX_DONE) begin
				byte_data   <= samp_q[8:1];
				parity_err  <= has_par && (ssale_pkg::parity_bit(samp_q[8:1], fmt.parity) != samp_q[9]);
				framing_err <= !samp_q[has_par ? 10 : 9] || (fmt.two_stop && !samp_q[has_par ? 11 : 10]);
			end else begin
				parity_err  <= 1'b0;
				framing_err <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ===== hw/ssale_tx.sv
// Character transmitter: shifts out start, data, optional parity and stop bits.
// Assumes the caller holds byte_data steady while byte_valid is high and byte_ready low.

`default_nettype none

module ssale_tx #(
	parameter int unsigned BIT_CYCLES = ssale_pkg::BIT_CYCLES
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// Line format
	input  wire ssale_pkg::ssale_fmt_s fmt,
	// Byte stream
	input  wire logic                  byte_valid,
	input  wire logic [7:0]            byte_data,
	output logic                       byte_ready,
	// Serial line
	output logic                       txd
);
	localparam int unsigned TW = $clog2(BIT_CYCLES + 1);

	logic [11:0]   shift_q;
	logic [3:0]    bits_q;
	logic [TW-1:0] tick_q;
	logic          has_par;

	assign has_par    = fmt.parity != ssale_pkg::PAR_NONE;
	assign byte_ready = bits_q == 4'h0;
	assign txd        = shift_q[0];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= 12'hfff;
			bits_q  <= 4'h0;
			tick_q  <= '0;
		end else if (byte_valid && byte_ready) begin
			shift_q <= has_par ? {2'h3, ssale_pkg::parity_bit(byte_data, fmt.parity), byte_data, 1'b0}
				: {3'h7, byte_data, 1'b0};
			bits_q  <= 4'ha + {3'h0, has_par} + {3'h0, fmt.two_stop};
			tick_q  <= TW'(BIT_CYCLES - 1);
		end else if (bits_q != 4'h0) begin
			if (tick_q != '0) begin
				tick_q <= tick_q - 1'b1;
			end else begin
				shift_q <= {1'b1, shift_q[11:1]};
				bits_q  <= bits_q - 4'h1;
				tick_q  <= TW'(BIT_CYCLES - 1);
			end
		end
	end

endmodule

`default_nettype wire

// ===== tb/ssale_master.sv
// Modbus master model: drives RTU frames onto the slave's receive line.
// Sends 8 data bits and one stop bit, BIT_CYCLES clocks per bit.
// On request it inserts an even-parity bit that is deliberately wrong.
`default_nettype none

module ssale_master #(
	parameter int unsigned BIT_CYCLES = 8
) (
	// Clock and line
	input  wire logic clock,
	output var logic  rxd
);
	timeunit 1ns;
	timeprecision 1ns;

	// The line idles high between frames, as a pulled-up bus would.
	initial rxd = 1'b1;

	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic send(input logic [7:0] q[$], input logic bad_crc, input logic bad_par = 1'b0);
		logic [15:0] c;
		logic [10:0] f;
		c = crc(q) ^ {15'h0000, bad_crc};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			f = {1'b1, (bad_par ? ~^q[i] : 1'b1), q[i], 1'b0};
			for (int b = 0; b < 10 + int'(bad_par); b++) begin
				rxd <= f[b];
				repeat (BIT_CYCLES) @(posedge clock);
			end
		end
	endtask
endmodule

`default_nettype wire

// ===== tb/serial_slave_access_log_errors_tb.sv
// Self-checking bench for the slave message block, with bit time 8 and gap 308 cycles.
// Assumes the master model in ssale_master and a register side played by this bench.
`default_nettype none

module serial_slave_access_log_errors_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [7:0] ADR = 8'h19;
	logic                     clock, arst_n, busy, result_valid, rxd, txd, query_valid, minor_fault_output;
	ssale_pkg::ssale_result_s result;
	ssale_pkg::ssale_query_s  query, q_exp;
	ssale_pkg::ssale_fmt_s    fmt;
	logic [15:0]              comm_error_counter;
	logic [7:0]               tx[$], f[$];
	logic [7:0]               fn[2] = '{8'h03, 8'h10};
	logic [7:0]               ex_f[3] = '{8'h07, 8'h03, 8'h03};
	logic [31:0]              seed;
	int                       mismatches, num_checks;

	always #25 clock = ~clock;

	ssale_slave #(.BIT_CYCLES(8), .GAP_CYCLES(308)) dut (.clock(clock), .arst_n(arst_n), .rxd(rxd), .txd(txd),
		.serial_format_setting(fmt), .own_addr(ADR), .busy(busy), .query_valid(query_valid), .query(query),
		.result_valid(result_valid), .result(result), .comm_error_counter(comm_error_counter),
		.minor_fault_output(minor_fault_output));
	ssale_master #(.BIT_CYCLES(8)) m (.clock(clock), .rxd(rxd));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic expect_reply(input logic [7:0] r[$]);
		logic [15:0] c;
		c = m.crc(r);
		tx = {tx, r, c[7:0], c[15:8]};
	endtask

	// Waiting on the reply queue keeps the next query clear of the current reply.
	task automatic run(input logic [7:0] q[$], input logic bad, input logic bad_par = 1'b0);
		m.send(q, bad, bad_par);
		repeat (400) @(posedge clock);
		for (int i = 0; i < 2000 && tx.size() != 0; i++) @(posedge clock);
		repeat (20) @(posedge clock);
	endtask

	// Any reply byte that nobody expects is a reply to a frame that had to stay unanswered.
	always begin : mon
		logic [7:0] b;
		@(negedge txd);
		repeat (4) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (8) @(posedge clock);
			b[i] = txd;
		end
		repeat (8) @(posedge clock);
		check(16'(tx.size() != 0), 16'h0001);
		if (tx.size() != 0) check({8'h00, b}, {8'h00, tx.pop_front()});
	end

	always @(posedge clock) begin
		if (query_valid) begin
			check(query.start, result.ok_start);
			check(query.count, q_exp.count);
			check({8'h00, query.func}, {8'h00, q_exp.func});
			repeat (3) @(posedge clock);
			result_valid <= 1'b1;
			@(posedge clock);
			result_valid <= 1'b0;
		end
	end

	initial begin
		repeat (40000) @(posedge clock);
		mismatches++;
		print_verdict();
	end

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		busy = 1'b0;
		result_valid = 1'b0;
		result = '0;
		fmt = '0;
		q_exp = '0;
		seed = 32'h4;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		expect_reply({ADR, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		run({ADR, 8'h46}, 1'b0);
		foreach (fn[i]) begin
			seed = xs(seed);
			result <= {seed[15:0], 16'h0002, 1'b0};
			q_exp = {fn[i], seed[15:0], 16'h0002};
			f = {ADR, fn[i], seed[15:8], seed[7:0], 8'h00, 8'h02};
			if (i == 1) f = {f, 8'h04, seed[31:24], seed[23:16], seed[31:24], seed[23:16]};
			run(f, 1'b0);
			expect_reply({ADR, 8'h46, seed[15:8], seed[7:0], 8'h00, 8'h02});
			run({ADR, 8'h46}, 1'b0);
			expect_reply({ADR, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
			run({ADR, 8'h46}, 1'b0);
		end
		for (int i = 0; i < 3; i++) begin
			result <= {32'h0000_0000, 1'(i == 2)};
			q_exp = {ex_f[i], 32'h0000_0001};
			expect_reply({ADR, ex_f[i] | 8'h80, 8'(i + 1)});
			run({ADR, ex_f[i], 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
		end
		run({8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
		busy <= 1'b1;
		run({ADR, 8'h46}, 1'b0);
		busy <= 1'b0;
		check(comm_error_counter, 16'h0000);
		run({ADR, 8'h46}, 1'b1);
		check(comm_error_counter, 16'h0001);
		check({15'h0000, minor_fault_output}, 16'h0001);
		run({ADR}, 1'b0);
		check(comm_error_counter, 16'h0002);
		// Every character of this frame carries a wrong parity bit, so each one counts.
		fmt <= '{ssale_pkg::PAR_EVEN, 1'b0};
		run({ADR, 8'h46}, 1'b0, 1'b1);
		fmt <= '0;
		check(comm_error_counter, 16'h0006);
		// A second query sent while the reply is still going out is an overrun for each character.
		expect_reply({ADR, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		m.send({ADR, 8'h46}, 1'b0);
		repeat (400) @(posedge clock);
		run({ADR, 8'h46}, 1'b0);
		check(comm_error_counter, 16'h000a);
		expect_reply({ADR, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00});
		run({ADR, 8'h46}, 1'b0);
		print_verdict();
	end
endmodule

`default_nettype wire
